// ### src/smvd_cfg.svh
`ifndef SMVD_CFG_SVH
`define SMVD_CFG_SVH
// format identification
`define SMVD_SCALAR_PROGRAM_FORMAT_ENC 9'h17f
`define SMVD_SCALAR_PROGRAM_FORMAT_ENC_HI 31
`define SMVD_SCALAR_PROGRAM_FORMAT_ENC_LO 23
`define SMVD_SCALAR_MEMORY_FORMAT_ENC 6'h30
`define SMVD_SCALAR_MEMORY_FORMAT_ENC_HI 31
`define SMVD_SCALAR_MEMORY_FORMAT_ENC_LO 26
`define SMVD_VECTOR_TWO_OPERAND_FORMAT_ENC_BIT 31
// program format fields
`define SMVD_SCALAR_PROGRAM_FORMAT_OP_HI 22
`define SMVD_SCALAR_PROGRAM_FORMAT_OP_LO 16
`define SMVD_SIMM_HI 15
`define SMVD_SIMM_LO 0
`define SMVD_SCALAR_PROGRAM_FORMAT_OP_MAX 7'h1e
// memory format fields, low word
`define SMVD_BASE_HI 5
`define SMVD_BASE_LO 0
`define SMVD_DATA_REG_FIELD_HI 12
`define SMVD_DATA_REG_FIELD_LO 6
`define SMVD_SOFF_EN_BIT 14
`define SMVD_NV_BIT 15
`define SMVD_BYPASS_BIT 16
`define SMVD_IMM_BIT 17
`define SMVD_SCALAR_MEMORY_FORMAT_OP_HI 25
`define SMVD_SCALAR_MEMORY_FORMAT_OP_LO 18
// memory format fields, high word (bit 32 is bit 0 here)
`define SMVD_OFF_HI 20
`define SMVD_OFF_LO 0
`define SMVD_SOFF_HI 31
`define SMVD_SOFF_LO 25
`define SMVD_SCALAR_GPR_MAX 7'h65
`define SMVD_M0_CODE 7'h7c
// two-operand vector fields
`define SMVD_VOP_OP_HI 30
`define SMVD_VOP_OP_LO 25
`define SMVD_VECTOR_DEST_HI 24
`define SMVD_VECTOR_DEST_LO 17
`define SMVD_VSRCB_HI 16
`define SMVD_VSRCB_LO 9
`define SMVD_VSRCA_HI 8
`define SMVD_VSRCA_LO 0
`define SMVD_VECTOR_TWO_OPERAND_FORMAT_OP_MAX 6'h3d
// register map
`define SMVD_ADDR_CTRL 8'h00
`define SMVD_ADDR_STATUS 8'h04
`define SMVD_ADDR_ILLCNT 8'h08
`define SMVD_CTRL_RST 32'h0000_0001
`define SMVD_RESP_OKAY 2'h0
`define SMVD_RESP_DECERR 2'h3
`endif

// ### src/smvd_pkg.sv
package smvd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HI = 2'b10
  } smvd_state_t;
  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } smvd_fetch_t;
  typedef struct packed {
    logic valid;
    logic [6:0] op;
    logic [31:0] operand;
  } smvd_sop_t;
  typedef struct packed {
    logic valid;
    logic [7:0] op;
    logic [6:0] base_reg;
    logic [6:0] data_reg;
    logic nonvol;
    logic bypass;
    logic imm_sel;
    logic [31:0] offset;
    logic [6:0] off_reg;
    logic soff_en;
    logic [6:0] soff_reg;
    logic neg_dropped;
  } smvd_scalar_memory_format_t;
  typedef struct packed {
    logic valid;
    logic [5:0] op;
    logic [8:0] src_a;
    logic [7:0] src_b;
    logic [7:0] dest;
  } smvd_vop_t;
endpackage

// ### src/smvd_scalar_memory_format_fields.sv
`timescale 1ns/1ps
`default_nettype none
`include "smvd_cfg.svh"
module smvd_scalar_memory_format_fields (
  input wire logic [31:0] i_lo,
  input wire logic [31:0] i_hi,
  output var smvd_pkg::smvd_scalar_memory_format_t o_fields,
  output logic o_bad
);
  import smvd_pkg::*;

  function automatic logic is_scalar_gpr(input logic [6:0] r);
    return r <= `SMVD_SCALAR_GPR_MAX;
  endfunction

  function automatic logic plain_ldst(input logic [7:0] op);
    return (op <= 8'h04) || (op >= 8'h10 && op <= 8'h12);
  endfunction

  function automatic logic op_listed(input logic [7:0] op);
    return (op <= 8'h0c) || (op >= 8'h10 && op <= 8'h1a) ||
      (op >= 8'h20 && op <= 8'h28) || (op >= 8'h40 && op <= 8'h4c) ||
      (op >= 8'h60 && op <= 8'h6c) || (op >= 8'h80 && op <= 8'h8c);
  endfunction

  logic [7:0] op;
  logic [20:0] off;
  logic [6:0] soff;
  logic neg;

  assign op = i_lo[`SMVD_SCALAR_MEMORY_FORMAT_OP_HI:`SMVD_SCALAR_MEMORY_FORMAT_OP_LO];
  assign off = i_hi[`SMVD_OFF_HI:`SMVD_OFF_LO];
  assign soff = i_hi[`SMVD_SOFF_HI:`SMVD_SOFF_LO];
  assign neg = i_lo[`SMVD_IMM_BIT] && off[20];

  always_comb begin
    o_fields = '0;
    o_fields.op = op;
    // pair or quad index: the dropped low address bit is zero
    o_fields.base_reg = {i_lo[`SMVD_BASE_HI:`SMVD_BASE_LO], 1'b0};
    o_fields.data_reg = i_lo[`SMVD_DATA_REG_FIELD_HI:`SMVD_DATA_REG_FIELD_LO];
    o_fields.nonvol = i_lo[`SMVD_NV_BIT];
    o_fields.bypass = i_lo[`SMVD_BYPASS_BIT];
    o_fields.imm_sel = i_lo[`SMVD_IMM_BIT];
    if (i_lo[`SMVD_IMM_BIT]) begin
      // only plain load and store see a negative offset
      if (neg && !plain_ldst(op)) begin
        o_fields.offset = {11'h000, off};
        o_fields.neg_dropped = 1'b1;
      end else begin
        o_fields.offset = {{11{off[20]}}, off};
      end
    end else begin
      o_fields.off_reg = off[6:0];
    end
    o_fields.soff_en = i_lo[`SMVD_SOFF_EN_BIT];
    if (i_lo[`SMVD_SOFF_EN_BIT]) begin
      o_fields.soff_reg = soff;
    end
  end

  // constant codes are refused as register offset or register-held offset
  assign o_bad = !op_listed(op) ||
    (i_lo[`SMVD_SOFF_EN_BIT] && !is_scalar_gpr(soff) &&
     soff != `SMVD_M0_CODE) ||
    (!i_lo[`SMVD_IMM_BIT] && (off[20:7] != 14'h0000 ||
     !is_scalar_gpr(off[6:0])));
endmodule // smvd_scalar_memory_format_fields
`default_nettype wire

// ### src/smvd_decode.sv
// Function
// - program format immediate sign-extended to 32 bits
// - memory base register index equals field times two
// - memory bits 12:6 select data scalar register
// - bit 16 bypasses cache or returns pre-op
// - bit 17 chooses immediate or register offset
// - negative immediate offset only for plain load/store
// - register offset used only when enabled, no constants
// - vector bits 16:9 source b, 24:17 destination
// - bit 31 zero marks two-operand vector format
`timescale 1ns/1ps
`default_nettype none
`include "smvd_cfg.svh"
module smvd_decode #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire smvd_pkg::smvd_fetch_t i_fetch,
  output var smvd_pkg::smvd_sop_t o_sop,
  output var smvd_pkg::smvd_scalar_memory_format_t o_scalar_memory_format,
  output var smvd_pkg::smvd_vop_t o_vop,
  output logic o_illegal,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  import smvd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0] ctrl;
  logic [15:0] ill_cnt;
  logic [2:0] last_fmt;
  logic enable;
  assign enable = ctrl[0];

  ////////////////////////////////////////////////////////////////////////////
  // format recognition

  smvd_state_t state;
  logic [31:0] w;
  logic [31:0] lo_q;
  logic take;
  logic idle;
  logic is_scalar_program_format;
  logic is_scalar_memory_format;
  logic is_vop;
  logic scalar_program_format_ok;
  logic vop_ok;
  logic scalar_memory_format_start;
  logic scalar_memory_format_done;
  logic scalar_memory_format_bad;
  logic bad_word;
  logic next_illegal;
  smvd_scalar_memory_format_t scalar_memory_format_fields;
  smvd_scalar_memory_format_t next_scalar_memory_format;

  assign w = i_fetch.word;
  assign take = i_fetch.valid && enable;
  assign idle = (state == ST_IDLE);
  assign is_scalar_program_format = w[`SMVD_SCALAR_PROGRAM_FORMAT_ENC_HI:`SMVD_SCALAR_PROGRAM_FORMAT_ENC_LO] == `SMVD_SCALAR_PROGRAM_FORMAT_ENC;
  assign is_scalar_memory_format = w[`SMVD_SCALAR_MEMORY_FORMAT_ENC_HI:`SMVD_SCALAR_MEMORY_FORMAT_ENC_LO] == `SMVD_SCALAR_MEMORY_FORMAT_ENC;
  assign is_vop = !w[`SMVD_VECTOR_TWO_OPERAND_FORMAT_ENC_BIT];
  assign scalar_program_format_ok = take && idle && is_scalar_program_format &&
    w[`SMVD_SCALAR_PROGRAM_FORMAT_OP_HI:`SMVD_SCALAR_PROGRAM_FORMAT_OP_LO] <= `SMVD_SCALAR_PROGRAM_FORMAT_OP_MAX;
  assign vop_ok = take && idle && is_vop &&
    w[`SMVD_VOP_OP_HI:`SMVD_VOP_OP_LO] <= `SMVD_VECTOR_TWO_OPERAND_FORMAT_OP_MAX;
  assign scalar_memory_format_start = take && idle && is_scalar_memory_format;
  assign scalar_memory_format_done = take && (state == ST_HI);
  // any other first word, or a program or vector word with unlisted opcode
  assign bad_word = take && idle && !scalar_program_format_ok && !vop_ok && !is_scalar_memory_format;
  assign next_illegal = bad_word || (scalar_memory_format_done && scalar_memory_format_bad);

  smvd_scalar_memory_format_fields u_fields (
    .i_lo(lo_q),
    .i_hi(w),
    .o_fields(scalar_memory_format_fields),
    .o_bad(scalar_memory_format_bad)
  );

  always_comb begin
    next_scalar_memory_format = scalar_memory_format_fields;
    next_scalar_memory_format.valid = scalar_memory_format_done && !scalar_memory_format_bad;
  end

  // the memory format is held until its second word arrives
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scalar_memory_format_start) begin
            state <= ST_HI;
          end
        end
        ST_HI: begin
          // disabling mid-instruction drops the half word
          if (!enable || i_fetch.valid) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lo_q <= 32'h0000_0000;
    end else if (scalar_memory_format_start) begin
      lo_q <= w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs, one cycle after the completing word

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sop <= '0;
    end else begin
      o_sop.valid <= scalar_program_format_ok;
      if (scalar_program_format_ok) begin
        o_sop.op <= w[`SMVD_SCALAR_PROGRAM_FORMAT_OP_HI:`SMVD_SCALAR_PROGRAM_FORMAT_OP_LO];
        o_sop.operand <= {{16{w[`SMVD_SIMM_HI]}},
          w[`SMVD_SIMM_HI:`SMVD_SIMM_LO]};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_scalar_memory_format <= '0;
    end else if (scalar_memory_format_done) begin
      o_scalar_memory_format <= next_scalar_memory_format;
    end else begin
      o_scalar_memory_format.valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_vop <= '0;
    end else begin
      o_vop.valid <= vop_ok;
      if (vop_ok) begin
        o_vop.op <= w[`SMVD_VOP_OP_HI:`SMVD_VOP_OP_LO];
        o_vop.src_a <= w[`SMVD_VSRCA_HI:`SMVD_VSRCA_LO];
        o_vop.src_b <= w[`SMVD_VSRCB_HI:`SMVD_VSRCB_LO];
        o_vop.dest <= w[`SMVD_VECTOR_DEST_HI:`SMVD_VECTOR_DEST_LO];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_illegal <= 1'b0;
    end else begin
      o_illegal <= next_illegal;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      last_fmt <= 3'h0;
    end else if (scalar_program_format_ok) begin
      last_fmt <= 3'h1;
    end else if (scalar_memory_format_done && !scalar_memory_format_bad) begin
      last_fmt <= 3'h2;
    end else if (vop_ok) begin
      last_fmt <= 3'h4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic cnt_clr;
  logic [31:0] next_ctrl;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  assign wr_fire = aw_hold && w_hold && !o_bvalid;
  assign rd_fire = i_arvalid && o_arready;
  assign cnt_clr = wr_fire && aw_addr == `SMVD_ADDR_ILLCNT;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      aw_hold <= 1'b0;
      o_awready <= 1'b0;
      aw_addr <= '0;
    end else if (o_awready && i_awvalid) begin
      aw_hold <= 1'b1;
      o_awready <= 1'b0;
      aw_addr <= i_awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
      o_awready <= 1'b1;
    end else if (!aw_hold) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      w_hold <= 1'b0;
      o_wready <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (o_wready && i_wvalid) begin
      w_hold <= 1'b1;
      o_wready <= 1'b0;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
      o_wready <= 1'b1;
    end else if (!w_hold) begin
      o_wready <= 1'b1;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_ctrl[8*b +: 8] = w_data[8*b +: 8];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl <= `SMVD_CTRL_RST;
    end else if (wr_fire && aw_addr == `SMVD_ADDR_CTRL) begin
      // only the enable bit is implemented
      ctrl <= {31'h0000_0000, next_ctrl[0]};
    end
  end

  // a new illegal word in the clearing cycle still counts
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ill_cnt <= 16'h0000;
    end else if (cnt_clr) begin
      ill_cnt <= {15'h0000, next_illegal};
    end else if (next_illegal && ill_cnt != 16'hffff) begin
      ill_cnt <= ill_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp <= `SMVD_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      if (aw_addr == `SMVD_ADDR_CTRL || aw_addr == `SMVD_ADDR_ILLCNT) begin
        o_bresp <= `SMVD_RESP_OKAY;
      end else if (aw_addr == `SMVD_ADDR_STATUS) begin
        o_bresp <= `SMVD_RESP_OKAY;
      end else begin
        o_bresp <= `SMVD_RESP_DECERR;
      end
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `SMVD_RESP_OKAY;
    if (i_araddr == `SMVD_ADDR_CTRL) begin
      rd_word = ctrl;
    end else if (i_araddr == `SMVD_ADDR_STATUS) begin
      rd_word = {27'h0000000, last_fmt, enable, state == ST_HI};
    end else if (i_araddr == `SMVD_ADDR_ILLCNT) begin
      rd_word = {16'h0000, ill_cnt};
    end else begin
      rd_resp = `SMVD_RESP_DECERR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `SMVD_RESP_OKAY;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_resp;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_scalar_program_format_seen;
    scalar_program_format_ok;
  endsequence

  sequence s_vop_seen;
    vop_ok;
  endsequence

  sequence s_scalar_memory_format_pair;
    scalar_memory_format_start ##1 (state == ST_HI && i_fetch.valid && enable);
  endsequence

  a_scalar_program_format_sign_ext: assert property (
    s_scalar_program_format_seen |=> o_sop.valid &&
      o_sop.operand == {{16{$past(w[15])}}, $past(w[15:0])})
    else $error("program immediate not sign-extended");

  a_base_pair: assert property (
    o_scalar_memory_format.valid |-> o_scalar_memory_format.base_reg == {lo_q[5:0], 1'b0})
    else $error("base register not field times two");

  a_data_select: assert property (
    o_scalar_memory_format.valid |-> o_scalar_memory_format.data_reg == lo_q[12:6])
    else $error("data register field wrong");

  a_bypass_bit: assert property (
    o_scalar_memory_format.valid |-> o_scalar_memory_format.bypass == lo_q[16])
    else $error("bypass bit not passed");

  a_offset_mode: assert property (
    o_scalar_memory_format.valid && !o_scalar_memory_format.imm_sel |->
      o_scalar_memory_format.offset == 32'h0000_0000 &&
      o_scalar_memory_format.off_reg == $past(w[6:0]))
    else $error("register offset mode wrong");

  a_signed_plain: assert property (
    o_scalar_memory_format.valid && o_scalar_memory_format.offset[31] |->
      (o_scalar_memory_format.op <= 8'h04 || (o_scalar_memory_format.op >= 8'h10 && o_scalar_memory_format.op <= 8'h12)))
    else $error("negative offset on non plain opcode");

  a_soff_gate: assert property (
    o_scalar_memory_format.valid && !o_scalar_memory_format.soff_en |-> o_scalar_memory_format.soff_reg == 7'h00)
    else $error("register offset used while disabled");

  a_vop_fields: assert property (
    s_vop_seen |=> o_vop.valid && o_vop.src_b == $past(w[16:9]) &&
      o_vop.dest == $past(w[24:17]))
    else $error("vector operand fields wrong");

  a_vop_detect: assert property (
    o_vop.valid |-> $past(w[31]) == 1'b0 && $past(state) == ST_IDLE)
    else $error("vector format without bit 31 clear");

  a_two_words: assert property (
    o_scalar_memory_format.valid |-> $past(state) == ST_HI && $past(i_fetch.valid))
    else $error("memory format issued before second word");

  a_pair_issue: assert property (
    s_scalar_memory_format_pair |=> o_scalar_memory_format.valid ^ o_illegal)
    else $error("memory pair neither issued nor flagged");

  a_illegal_quiet: assert property (
    o_illegal |-> !o_sop.valid && !o_vop.valid && !o_scalar_memory_format.valid)
    else $error("illegal word also issued");

endmodule // smvd_decode
`default_nettype wire

// ### bench/smvd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module smvd_fetch_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_send,
  input wire logic [31:0] i_word,
  output var smvd_pkg::smvd_fetch_t o_fetch
);
  import smvd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // words go out in the order offered, memory low word first
  // an idle bus alternates each cycle between the inverse of the last word and the last word itself
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_fetch <= '0;
    end else if (i_send) begin
      o_fetch.valid <= 1'b1;
      o_fetch.word <= i_word;
    end else begin
      o_fetch.valid <= 1'b0;
      o_fetch.word <= ~o_fetch.word;
    end
  end
endmodule // smvd_fetch_model
`default_nettype wire

// ### bench/smvd_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module smvd_decode_tb_top;
  import smvd_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic send = 1'b0;
  logic [31:0] word = 32'h0;
  smvd_fetch_t fetch;
  smvd_sop_t sop;
  smvd_scalar_memory_format_t scalar_memory_format;
  smvd_vop_t vop;
  logic illegal, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  int errors = 0;
  int total_checks = 0;
  always #25 i_clk = ~i_clk;
  smvd_fetch_model fm_u (.i_clk(i_clk), .i_srst(i_srst), .i_send(send),
    .i_word(word), .o_fetch(fetch));
  smvd_decode dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_fetch(fetch),
    .o_sop(sop), .o_scalar_memory_format(scalar_memory_format), .o_vop(vop), .o_illegal(illegal),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge i_clk);
    awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d; wstrb <= s;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    @(posedge i_clk);
    arvalid <= 1; araddr <= a; rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask
  // sends one or two words, then reports which output pulsed
  task automatic issue(input logic [31:0] w0, input logic [31:0] w1,
                       input bit two, input logic [3:0] k);
    logic [3:0] seen;
    int n;
    @(posedge i_clk); send <= 1; word <= w0;
    if (two) begin
      @(posedge i_clk); word <= w1;
    end
    @(posedge i_clk); send <= 0;
    seen = 4'h0;
    for (n = 0; n < 4 && seen == 4'h0; n++) begin
      @(posedge i_clk); #1;
      seen = {illegal, vop.valid, scalar_memory_format.valid, sop.valid};
    end
    check({28'h0, seen}, {28'h0, k});
  endtask
  function automatic logic [31:0] mlo(input logic [7:0] op, input logic imm_offset_select,
    input logic byp, input logic sen, input logic [6:0] sd,
    input logic [5:0] sb);
    return {6'h30, op, imm_offset_select, byp, 1'b0, sen, 1'b0, sd, sb};
  endfunction
  function automatic logic [31:0] mhi(input logic [6:0] so,
                                      input logic [20:0] off);
    return {so, 4'h0, off};
  endfunction
  task automatic chk_mem(input logic [6:0] b, input logic [6:0] d,
    input logic byp, input logic [31:0] off, input logic [6:0] oreg,
    input logic [6:0] sreg, input logic neg);
    check(32'(scalar_memory_format.base_reg), 32'(b));
    check(32'(scalar_memory_format.data_reg), 32'(d));
    check(32'(scalar_memory_format.bypass), 32'(byp));
    check(scalar_memory_format.offset, off);
    check(32'(scalar_memory_format.off_reg), 32'(oreg));
    check(32'(scalar_memory_format.soff_reg), 32'(sreg));
    check(32'(scalar_memory_format.neg_dropped), 32'(neg));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 50);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 0;
    repeat (2) @(posedge i_clk);
    axi_rd(8'h00, 32'h1, 2'h0);
    axi_rd(8'h04, 32'h2, 2'h0);
    axi_rd(8'h08, 32'h0, 2'h0);
    axi_rd(8'h0c, 32'h0, 2'h3);
    $display("test registers done");
    issue({9'h17f, 7'd30, 16'h8001}, 32'h0, 0, 4'b0001);
    check(sop.operand, 32'hffff8001);
    check(32'(sop.op), 32'd30);
    issue({9'h17f, 7'd2, 16'h7ffe}, 32'h0, 0, 4'b0001);
    check(sop.operand, 32'h00007ffe);
    $display("test program done");
    issue({1'b0, 6'd61, 8'ha5, 8'h3c, 9'h1f0}, 32'h0, 0, 4'b0100);
    check(32'(vop.src_b), 32'h3c);
    check(32'(vop.dest), 32'ha5);
    check(32'(vop.src_a), 32'h1f0);
    check(32'(vop.op), 32'd61);
    $display("test vector done");
    issue(mlo(8'd0, 1, 1, 1, 7'h33, 6'h05), mhi(7'h7c, 21'h1ffff0), 1,
      4'b0010);
    chk_mem(7'h0a, 7'h33, 1, 32'hfffffff0, 7'h0, 7'h7c, 0);
    issue(mlo(8'd8, 1, 0, 0, 7'h01, 6'h3f), mhi(7'h10, 21'h1ffff0), 1,
      4'b0010);
    chk_mem(7'h7e, 7'h01, 0, 32'h001ffff0, 7'h0, 7'h0, 1);
    issue(mlo(8'd64, 0, 1, 1, 7'h00, 6'h00), mhi(7'h65, 21'h21), 1,
      4'b0010);
    chk_mem(7'h00, 7'h00, 1, 32'h0, 7'h21, 7'h65, 0);
    $display("test memory done");
    issue({9'h17f, 7'd31, 16'h0}, 32'h0, 0, 4'b1000);
    issue({1'b0, 6'd62, 25'h0}, 32'h0, 0, 4'b1000);
    issue(32'hffffffff, 32'h0, 0, 4'b1000);
    issue(mlo(8'd13, 1, 0, 0, 7'h0, 6'h0), mhi(7'h0, 21'h4), 1,
      4'b1000);
    issue(mlo(8'd0, 1, 0, 1, 7'h0, 6'h0), mhi(7'h66, 21'h4), 1,
      4'b1000);
    issue(mlo(8'd0, 0, 0, 0, 7'h0, 6'h0), mhi(7'h0, 21'h66), 1,
      4'b1000);
    axi_rd(8'h08, 32'h6, 2'h0);
    axi_wr(8'h08, 32'h0, 4'hf, 2'h0);
    axi_rd(8'h08, 32'h0, 2'h0);
    $display("test illegal done");
    axi_wr(8'h00, 32'h0, 4'h0, 2'h0);
    axi_rd(8'h00, 32'h1, 2'h0);
    axi_wr(8'h00, 32'h0, 4'h1, 2'h0);
    issue({1'b0, 6'd1, 25'h0}, 32'h0, 0, 4'b0000);
    axi_wr(8'h04, 32'hff, 4'hf, 2'h0);
    axi_rd(8'h04, 32'h08, 2'h0);
    axi_wr(8'h10, 32'h1, 4'hf, 2'h3);
    axi_wr(8'h00, 32'h1, 4'hf, 2'h0);
    issue({1'b0, 6'd1, 25'h0}, 32'h0, 0, 4'b0100);
    $display("test enable done");
    wrap_up();
  end
endmodule // smvd_decode_tb_top
`default_nettype wire
